// ---- design/lpsm_consts.vh ----
// Constants for the actuator period and supply monitor register bank
`ifndef LPSM_CONSTS_VH
`define LPSM_CONSTS_VH
// Register offsets
`define LPSM_OFS_OL_PERIOD 8'h20
`define LPSM_OFS_SUPPLY 8'h21
`define LPSM_OFS_RES_PERIOD 8'h22
// Reset values
`define LPSM_RST_OL_PERIOD 8'h00
`define LPSM_RST_SUPPLY 8'h00
`define LPSM_RST_RES_PERIOD 8'h00
// Field position of the 7-bit open-loop period code
`define LPSM_OL_CODE_MSB 6
// Period unit in nanoseconds (98.46 us) and clock period in ns
`define LPSM_PERIOD_UNIT_NS 98460
`define LPSM_CLK_NS 25
// Cycles per period unit, rounded down (98460 / 25 = 3938)
`define LPSM_UNIT_CYC (`LPSM_PERIOD_UNIT_NS / `LPSM_CLK_NS)
// Last count of the half-unit timer (1969 cycles, two make one unit)
`define LPSM_HALF_LAST 11'h7b0
// Missing back-EMF half cycles before open-loop fallback
`define LPSM_BEMF_MISS_MAX 4'h5
`endif

// ---- design/lpsm_top.v ----
// Period, supply and resonance register bank with drive timing
// Summary of operation
// - Open-loop drive period equals seven-bit code times 98.46 us.
// - Supply code register shows supply, sampled only while driving.
// - Resonance period register reports measured half-cycle pairs in units.
// - Resonance locks after half a cycle and tracks back-EMF each cycle.
// - Tracking needs no calibration; calibration input never touches it.
// - Trigger pin rising edge starts the loaded effect only while ext_trig_mode_i is set.
// - Rotating-mass drive outputs either polarity on both outputs.
// - Auto open-loop select enables fallback when back-EMF missing.
//
////////////////////////////////////////////////////////////////////////
// Timing notes
// The shared timer ticks every half period unit while driving.
// Open-loop drive flips phase every code half units, so the full
// drive period is the code in whole units.
// Resonance is measured in half units over a full back-EMF cycle,
// then halved into whole units before it reaches the readout.
// The half-unit count saturates, so a very slow actuator reads 0xff.
// A tick that meets a crossing is still counted, so no unit is lost.
// The first reading after a start spans the time since the start,
// later readings span exactly two crossings.
// Fallback counts half periods without any crossing; one crossing
// clears the count again.
// Readout writes from the host only land while nothing is driven,
// so a write can never fight a fresh measurement.
// Start wins over stop when idle; stop ends a running waveform.
// The calibration input is left unused on purpose: tracking must
// behave the same whether or not a calibration is running.
//
////////////////////////////////////////////////////////////////////////
`default_nettype none
`include "lpsm_consts.vh"
module lpsm_top (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Mode and triggers
  input wire bus_go_i,
  input wire input_trigger_pin_i,
  input wire ext_trig_mode_i,
  input wire stop_i,
  input wire lra_mode_i,
  input wire open_loop_mode_i,
  input wire auto_open_loop_select_i,
  input wire auto_cal_i,
  input wire erm_reverse_i,
  // Sensing
  input wire [7:0] supply_sample_i,
  input wire bemf_zero_cross_i,
  // Drive outputs
  output reg drive_p_o,
  output reg drive_n_o,
  output reg active_o,
  output reg open_loop_o
);
  reg [7:0] ol_period_reg;
  reg [7:0] supply_reg;
  reg [7:0] res_period_reg;
  reg trig_d_reg;
  reg [7:0] half_cnt_reg;
  // Measured cycle length in half units
  reg [8:0] meas_cnt_reg;
  reg [3:0] miss_reg;
  reg phase_reg;
  wire tick;
  wire start;
  wire [6:0] ol_code;
  wire half_done;

  // Sets a register byte from a write or holds
  function [7:0] wr_byte;
    input [7:0] ofs;
    input [7:0] cur;
    begin
      wr_byte = (reg_wr_i && reg_addr_i == ofs) ? reg_wdata_i : cur;
    end
  endfunction

  lpsm_unit_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(active_o),
    .tick_o(tick)
  );

  assign ol_code = ol_period_reg[`LPSM_OL_CODE_MSB:0];
  assign start = bus_go_i || (ext_trig_mode_i && input_trigger_pin_i && !trig_d_reg);
  assign half_done = tick && (half_cnt_reg[6:0] + 7'h01 >= ol_code);

  ////////////////////////////////////////////////////////////////////////
  // Register file; readouts also host-writable. bus access
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ol_period_reg <= `LPSM_RST_OL_PERIOD;
      supply_reg <= `LPSM_RST_SUPPLY;
      res_period_reg <= `LPSM_RST_RES_PERIOD;
    end
    else
    begin
      ol_period_reg <= wr_byte(`LPSM_OFS_OL_PERIOD, ol_period_reg);
      if (active_o)
        supply_reg <= supply_sample_i;
      else
        supply_reg <= wr_byte(`LPSM_OFS_SUPPLY, supply_reg);
      if (active_o && lra_mode_i && !open_loop_o && bemf_zero_cross_i && phase_reg)
        res_period_reg <= meas_cnt_reg[8:1]; // Half units to units
      else if (!active_o)
        res_period_reg <= wr_byte(`LPSM_OFS_RES_PERIOD, res_period_reg);
    end
  end

  // Read mux
  always @(posedge clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else
      case (reg_addr_i)
        `LPSM_OFS_OL_PERIOD: reg_rdata_o <= ol_period_reg;
        `LPSM_OFS_SUPPLY: reg_rdata_o <= supply_reg;
        `LPSM_OFS_RES_PERIOD: reg_rdata_o <= res_period_reg;
        default: reg_rdata_o <= 8'h00;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Drive engine; auto_cal_i deliberately unused here
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_d_reg <= 1'b0;
      active_o <= 1'b0;
      open_loop_o <= 1'b0;
      half_cnt_reg <= 8'h00;
      meas_cnt_reg <= 9'h000;
      miss_reg <= 4'h0;
      phase_reg <= 1'b0;
      drive_p_o <= 1'b0;
      drive_n_o <= 1'b0;
    end
    else
    begin
      trig_d_reg <= input_trigger_pin_i;
      if (start && !active_o)
      begin
        active_o <= 1'b1;
        open_loop_o <= open_loop_mode_i;
        half_cnt_reg <= 8'h00;
        meas_cnt_reg <= 9'h000;
        miss_reg <= 4'h0;
        phase_reg <= 1'b0;
      end
      else if (stop_i)
        active_o <= 1'b0;
      else if (active_o)
      begin
        if (lra_mode_i && !open_loop_o && bemf_zero_cross_i)
        begin
          phase_reg <= ~phase_reg;
          miss_reg <= 4'h0;
          half_cnt_reg <= 8'h00;
          // New cycle keeps a coinciding tick
          if (phase_reg)
            meas_cnt_reg <= {8'h00, tick};
          else if (tick && meas_cnt_reg != 9'h1ff)
            meas_cnt_reg <= meas_cnt_reg + 9'h001;
        end
        else if (tick)
        begin
          // Saturating half-unit count
          if (meas_cnt_reg != 9'h1ff)
            meas_cnt_reg <= meas_cnt_reg + 9'h001;
          if (half_done || !lra_mode_i)
          begin
            half_cnt_reg <= 8'h00;
            if (lra_mode_i && open_loop_o)
              phase_reg <= ~phase_reg;
            if (lra_mode_i && !open_loop_o && auto_open_loop_select_i)
            begin
              if (miss_reg == `LPSM_BEMF_MISS_MAX)
                open_loop_o <= 1'b1;
              else
                miss_reg <= miss_reg + 4'h1;
            end
          end
          else
            half_cnt_reg <= half_cnt_reg + 8'h01;
        end
      end
      if (!active_o)
      begin
        drive_p_o <= 1'b0;
        drive_n_o <= 1'b0;
      end
      else if (lra_mode_i)
      begin
        drive_p_o <= ~phase_reg;
        drive_n_o <= phase_reg;
      end
      else
      begin
        drive_p_o <= ~erm_reverse_i;
        drive_n_o <= erm_reverse_i;
      end
    end
  end
endmodule // lpsm_top
`default_nettype wire

// ---- design/lpsm_unit_timer.v ----
// Timer that ticks once per half period unit (two ticks per 98.46 us)
`default_nettype none
`include "lpsm_consts.vh"
module lpsm_unit_timer (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Control
  input wire run_i,
  // Tick out
  output reg tick_o
);
  reg [10:0] cnt_reg;
  reg [10:0] cnt_next;

  // Next count value
  always @*
  begin
    cnt_next = cnt_reg + 11'h001;
    if (!run_i || cnt_reg == `LPSM_HALF_LAST)
      cnt_next = 11'h000;
  end

  // Counter and tick register
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= 11'h000;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_o <= run_i && (cnt_reg == `LPSM_HALF_LAST);
    end
  end
endmodule // lpsm_unit_timer
`default_nettype wire

// ---- test/lpsm_act_model.sv ----
// Actuator model giving back-EMF crossings while driven
`default_nettype none
module lpsm_act_model (
  // Drive state and settings
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic en_i,
  input wire logic [15:0] half_i,
  // Crossing pulse
  output logic zc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_reg;
  // One pulse per half cycle, none when back-EMF is absent
  always @(posedge clk_i)
  begin
    cnt_reg <= (run_i && cnt_reg < half_i - 1) ? cnt_reg + 1 : 16'h0000;
    zc_o <= run_i && en_i && cnt_reg == half_i - 1;
  end
endmodule // lpsm_act_model
`default_nettype wire

// ---- test/lpsm_chk.sv ----
// Assertion checker for the period and supply register bank
`default_nettype none
module lpsm_chk (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic bus_go_i,
  input wire logic input_trigger_pin_i,
  input wire logic ext_trig_mode_i,
  input wire logic lra_mode_i,
  input wire logic auto_open_loop_select_i,
  input wire logic [7:0] supply_sample_i,
  input wire logic drive_p_o,
  input wire logic drive_n_o,
  input wire logic active_o,
  input wire logic open_loop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_wr;
    reg_wr_i && reg_addr_i == 8'h20 ##1 reg_addr_i == 8'h20 |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("period readback wrong");
  property p_go; !active_o && bus_go_i |=> active_o; endproperty
  a_go: assert property (p_go) else $error("bus start lost");
  property p_trg; !active_o && ext_trig_mode_i && $rose(input_trigger_pin_i) |=> active_o; endproperty
  a_trg: assert property (p_trg) else $error("trigger start lost");
  property p_sup; active_o ##1 reg_addr_i == 8'h21 |=> reg_rdata_o == $past(supply_sample_i, 2); endproperty
  a_sup: assert property (p_sup) else $error("supply not followed");
  property p_hold; !active_o && !reg_wr_i ##1 $stable(reg_addr_i) |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("readout moved while idle");
  property p_erm; $past(active_o) && active_o && !$past(lra_mode_i) |-> drive_p_o != drive_n_o; endproperty
  a_erm: assert property (p_erm) else $error("motor drive not differential");
  property p_off; !active_o && !$past(active_o) |-> !drive_p_o && !drive_n_o; endproperty
  a_off: assert property (p_off) else $error("drive while idle");
  property p_ol;
    active_o && $past(active_o) && $past(active_o, 2) && !open_loop_o && !auto_open_loop_select_i
      |=> !open_loop_o;
  endproperty
  a_ol: assert property (p_ol) else $error("open loop without select");
  // Main scenarios reached
  c_trg: cover property (ext_trig_mode_i && $rose(input_trigger_pin_i));
  c_sup: cover property (active_o && reg_addr_i == 8'h21);
  c_ol: cover property ($rose(open_loop_o));
endmodule // lpsm_chk
bind lpsm_top lpsm_chk lpsm_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .bus_go_i(bus_go_i), .input_trigger_pin_i(input_trigger_pin_i),
  .ext_trig_mode_i(ext_trig_mode_i), .lra_mode_i(lra_mode_i),
  .auto_open_loop_select_i(auto_open_loop_select_i), .supply_sample_i(supply_sample_i),
  .drive_p_o(drive_p_o), .drive_n_o(drive_n_o), .active_o(active_o),
  .open_loop_o(open_loop_o));
`default_nettype wire

// ---- test/lpsm_top_tb.sv ----
// Self-checking bench for the period and supply register bank
`default_nettype none
`include "lpsm_consts.vh"
module lpsm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, reg_wr_i = 0, bus_go_i = 0, input_trigger_pin_i = 0;
  logic ext_trig_mode_i = 0, stop_i = 0, lra_mode_i = 0, open_loop_mode_i = 0;
  logic auto_open_loop_select_i = 0, auto_cal_i = 0, erm_reverse_i = 0, en = 1;
  logic bemf_zero_cross_i, drive_p_o, drive_n_o, active_o, open_loop_o;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, supply_sample_i = 0, reg_rdata_o, v;
  logic [15:0] half = 0;
  int fail_count = 0, checks = 0, seed = 84751, h;
  time t0;
  lpsm_top lpsm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .bus_go_i(bus_go_i), .input_trigger_pin_i(input_trigger_pin_i),
    .ext_trig_mode_i(ext_trig_mode_i), .stop_i(stop_i), .lra_mode_i(lra_mode_i),
    .open_loop_mode_i(open_loop_mode_i), .auto_open_loop_select_i(auto_open_loop_select_i),
    .auto_cal_i(auto_cal_i), .erm_reverse_i(erm_reverse_i), .supply_sample_i(supply_sample_i),
    .bemf_zero_cross_i(bemf_zero_cross_i), .drive_p_o(drive_p_o), .drive_n_o(drive_n_o),
    .active_o(active_o), .open_loop_o(open_loop_o));
  lpsm_act_model lpsm_act_model_inst (.clk_i(clk_i), .run_i(active_o), .en_i(en),
    .half_i(half), .zc_o(bemf_zero_cross_i));
  initial forever #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  // Expected period code, one unit per full cycle
  function automatic logic [7:0] res_exp(input int hh);
    res_exp = (2 * hh / `LPSM_UNIT_CYC > 255) ? 8'hff : 8'(2 * hh / `LPSM_UNIT_CYC);
  endfunction
  task chk(input logic [31:0] g, e);
    checks++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask
  task rdc(input logic [7:0] a, e);
    @(posedge clk_i) reg_addr_i <= a;
    @(posedge clk_i) #1 chk(reg_rdata_o, e);
  endtask
  task wrt(input logic [7:0] a, d);
    @(posedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge clk_i) reg_wr_i <= 0;
  endtask
  task stop;
    @(posedge clk_i) stop_i <= 1;
    @(posedge clk_i) stop_i <= 0;
  endtask
  task results;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rdc(8'h20, 0);
    rdc(8'h21, 0);
    rdc(8'h22, 0);
    rdc(8'h23, 0);
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 8'h7f : 8'($random(seed)) & 8'h7f;
      wrt(8'h20, v);
      rdc(8'h20, v);
    end
    $display("test registers done");
    @(posedge clk_i) {ext_trig_mode_i, erm_reverse_i, input_trigger_pin_i} <= {2'b11, 1'b1};
    @(posedge clk_i) input_trigger_pin_i <= 0;
    repeat (3) @(posedge clk_i);
    #1 chk({7'h0, active_o}, 1);
    stop;
    $display("test trigger done");
    v = $random(seed);
    h = 1969 * (1 + {$random(seed)} % 2) + 900;
    @(posedge clk_i) {half, lra_mode_i, bus_go_i, supply_sample_i} <= {h[15:0], 2'b11, v};
    @(posedge clk_i) {bus_go_i, ext_trig_mode_i} <= 2'b00;
    repeat (5 * h) @(posedge clk_i) auto_cal_i <= $random(seed);
    rdc(8'h21, v);
    wrt(8'h22, 8'hff);
    stop;
    rdc(8'h22, res_exp(h));
    rdc(8'h21, v);
    $display("test resonance done");
    // Short open-loop code keeps the fallback wait short
    wrt(8'h20, 8'h02);
    @(posedge clk_i) {auto_open_loop_select_i, en, bus_go_i} <= 3'b101;
    @(posedge clk_i) bus_go_i <= 0;
    for (h = 0; h < 60000 && open_loop_o !== 1; h++) @(posedge clk_i);
    #1 chk({7'h0, open_loop_o}, 1);
    stop;
    wrt(8'h21, 8'h5a);
    rdc(8'h21, 8'h5a);
    $display("test fallback done");
    // Open-loop drive: one full period is the code in whole units
    @(posedge clk_i) {open_loop_mode_i, bus_go_i} <= 2'b11;
    @(posedge clk_i) bus_go_i <= 0;
    repeat (2) @(posedge drive_p_o);
    t0 = $time;
    @(posedge drive_p_o);
    chk(32'(($time - t0) / `LPSM_CLK_NS), 2 * `LPSM_UNIT_CYC);
    stop;
    $display("test open loop done");
    results;
  end
  // Watchdog against a hang
  initial
  begin
    repeat (95000) @(posedge clk_i);
    fail_count++;
    results;
  end
endmodule // lpsm_top_tb
`default_nettype wire
